// File: dv/tb_vtrack.sv
// bench for the supply min/max tracker
// drives apb and samples itself; checker bound at the foot
`timescale 1ns/1ps
module tb_vtrack;
  logic        sys_clk = 1'b0;
  logic        resetn  = 1'b0;
  logic [11:0] main_s  = 12'h000;
  logic [11:0] sec_s   = 12'h000;
  logic        s_vld   = 1'b0;
  logic        clr     = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  logic        pready, pslverr, sel, e;
  logic [31:0] prdata, r;
  int          errors = 0;
  int          samples_checked = 0;
  always #25 sys_clk = ~sys_clk;
  vtrack uut (.sys_clk(sys_clk), .resetn(resetn), .main_battery_sample(main_s),
    .secondary_supply_sample(sec_s), .sample_valid(s_vld), .clear_req(clr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .supply_config_select(sel));
  task automatic tally_and_finish();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    samples_checked++;
    if (g !== x) begin
      errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  // hold drives the sample strobe for as long as the access is addressed
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic hold);
    int n;
    n = 0;
    @(posedge sys_clk);
    {psel, pwrite, paddr, pwdata, s_vld} <= {1'b1, w, a, d, hold};
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1 && ++n < 20);
    if (n >= 20) begin
      errors++;
      tally_and_finish();
    end
    r = prdata;
    e = pslverr;
    {psel, penable, s_vld} <= 3'h0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, 1'b0);
    chk(r, x);
    chk({31'h0, e}, 32'h0);
  endtask
  task automatic smp(input logic [11:0] m, input logic [11:0] s);
    @(posedge sys_clk);
    {main_s, sec_s, s_vld} <= {m, s, 1'b1};
    @(posedge sys_clk);
    s_vld <= 1'b0;
  endtask
  initial begin
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    rd(12'h074, 32'h0);
    rd(12'h078, 32'h0);
    rd(12'h07C, 32'h0);
    @(posedge sys_clk) clr <= 1'b1;
    @(posedge sys_clk) clr <= 1'b0;
    rd(12'h074, 32'hF);
    rd(12'h078, 32'hFF);
    smp(12'h523, 12'h001);
    smp(12'h1A4, 12'hFFE);
    smp(12'h7E9, 12'h002);
    rd(12'h074, 32'h1);
    rd(12'h078, 32'hA4);
    rd(12'h07C, 32'h7);
    rd(12'h080, 32'hE9);
    $display("test main pin tracking done");
    apb(1'b1, 12'h0C0, 32'h3, 1'b0);
    chk({31'h0, sel}, 32'h1);
    rd(12'h0C0, 32'h1);
    rd(12'h07C, 32'h0);
    smp(12'h001, 12'h050);
    smp(12'hFFE, 12'hA10);
    rd(12'h074, 32'h0);
    smp(12'hFFE, 12'h033);
    rd(12'h078, 32'h50);
    rd(12'h074, 32'h0);
    rd(12'h078, 32'h33);
    sec_s <= 12'hFFE;
    apb(1'b0, 12'h07C, 32'h0, 1'b1);
    chk(r, 32'hA);
    rd(12'h080, 32'h10);
    rd(12'h07C, 32'hA);
    apb(1'b1, 12'h074, 32'h0, 1'b0);
    rd(12'h074, 32'h0);
    apb(1'b0, 12'h400, 32'h0, 1'b0);
    chk({r[30:0], e}, 32'h1);
    $display("test secondary pin and hold-off done");
    tally_and_finish();
  end
endmodule
bind vtrack vtrack_monitor mon (.sys_clk(sys_clk), .resetn(resetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .supply_config_select(supply_config_select));

// File: dv/vtrack_monitor.sv
// apb port checks for the supply min/max tracker
// bound to vtrack from the bench top
`timescale 1ns/1ps
module vtrack_monitor (
  input wire logic        sys_clk,             // clock
  input wire logic        resetn,              // reset, active low
  input wire logic        psel,                // select
  input wire logic        penable,             // enable
  input wire logic        pwrite,              // direction
  input wire logic [11:0] paddr,               // byte address
  input wire logic        pready,              // ready
  input wire logic [31:0] prdata,              // read data
  input wire logic        pslverr,             // error
  input wire logic        supply_config_select // tracked pin
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  chk_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("no answer after one wait");
  chk_idle_data: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  chk_hi_upper: assert property (pready && !pwrite && (paddr == 12'h074 ||
    paddr == 12'h07C) |-> prdata[31:4] == 28'h0)
    else $error("high nibble upper bits set");
  chk_ro_write: assert property (pready && pwrite &&
    paddr inside {12'h074, 12'h078, 12'h07C, 12'h080} |-> !pslverr)
    else $error("tracker write flagged");
  chk_bad_addr: assert property (pready && (paddr[1:0] != 2'h0 ||
    paddr[11:10] != 2'h0) |-> pslverr && prdata == 32'h0)
    else $error("bad address not flagged");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_sel_write: assert property ($changed(supply_config_select) |->
    $past(psel && pwrite && paddr == 12'h0C0))
    else $error("select moved without write");
endmodule

// File: pkg/vtrack_pkg.sv
// constants and carrier types for the supply min/max tracker
// assumes a 32-bit apb slave with one register per aligned word
package vtrack_pkg;
  // printed offsets are register indices; byte address is four times these
  localparam logic [7:0] IDX_MIN_HI   = 8'h1D;
  localparam logic [7:0] IDX_MIN_LO   = 8'h1E;
  localparam logic [7:0] IDX_MAX_HI   = 8'h1F;
  localparam logic [7:0] IDX_MAX_LO   = 8'h20;
  localparam logic [7:0] IDX_CTRL     = 8'h30;
  localparam logic [7:0] RESET_BYTE   = 8'h00;
  localparam logic [11:0] MIN_CLEARED = 12'hFFF;
  localparam logic [11:0] MAX_CLEARED = 12'h000;
  localparam logic [11:0] SAMPLE_RESET = 12'h000;
  localparam int CTRL_SEL_BIT = 0;
  localparam int CTRL_CLR_BIT = 1;

  typedef struct packed {
    logic [11:0] min_v;
    logic [11:0] max_v;
    logic [7:0]  min_lo_shadow;
    logic [7:0]  max_lo_shadow;
    logic        supply_config_select;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } state_t;
endpackage

// File: rtl/vtrack.sv
// supply voltage min/max tracker with apb register access
// assumes samples and their valid strobe come from logic on sys_clk
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps

module vtrack (
  input  wire logic        sys_clk,       // 20 MHz clock
  input  wire logic        resetn,        // async reset, active low
  input  wire logic [11:0] main_battery_sample,   // main battery reading
  input  wire logic [11:0] secondary_supply_sample, // secondary reading
  input  wire logic        sample_valid,  // one-cycle sample strobe
  input  wire logic        clear_req,     // one-cycle clear pulse
  input  wire logic        psel,          // apb select
  input  wire logic        penable,       // apb enable
  input  wire logic        pwrite,        // apb direction
  input  wire logic [11:0] paddr,         // apb byte address
  input  wire logic [31:0] pwdata,        // apb write data
  output logic             pready,        // apb ready
  output logic [31:0]      prdata,        // apb read data
  output logic             pslverr,       // apb error
  output logic             supply_config_select // tracked pin select
);
  vtrack_pkg::state_t s_q;
  vtrack_pkg::state_t s_d;

  logic [9:0]  idx;
  logic        aligned;
  logic        acc;
  logic        hit_min;
  logic        hit_max;
  logic [11:0] smp;

  assign idx     = paddr[11:2];
  assign aligned = (paddr[1:0] == 2'b00);
  assign acc     = psel && penable && !s_q.pready;
  // hold-off covers setup and access phases
  assign hit_min = psel && aligned && (idx == {2'b00, vtrack_pkg::IDX_MIN_HI}
                   || idx == {2'b00, vtrack_pkg::IDX_MIN_LO});
  assign hit_max = psel && aligned && (idx == {2'b00, vtrack_pkg::IDX_MAX_HI}
                   || idx == {2'b00, vtrack_pkg::IDX_MAX_LO});

  always_comb begin
    s_d    = s_q;
    smp    = s_q.supply_config_select ? secondary_supply_sample
                                      : main_battery_sample;
    s_d.pready  = acc;
    s_d.pslverr = 1'b0;
    if (!acc) begin
      s_d.prdata = 32'h0000_0000;
    end
    if (clear_req) begin
      s_d.min_v = vtrack_pkg::MIN_CLEARED;
      s_d.max_v = vtrack_pkg::MAX_CLEARED;
    end else if (sample_valid) begin
      if (!hit_min && smp < s_q.min_v) begin
        s_d.min_v = smp;
      end
      if (!hit_max && smp > s_q.max_v) begin
        s_d.max_v = smp;
      end
    end
    if (acc) begin
      s_d.prdata = 32'h0000_0000;
      if (!aligned) begin
        s_d.pslverr = 1'b1;
      end else if (pwrite) begin
        if (idx == {2'b00, vtrack_pkg::IDX_CTRL}) begin
          s_d.supply_config_select = pwdata[vtrack_pkg::CTRL_SEL_BIT];
          if (pwdata[vtrack_pkg::CTRL_CLR_BIT]) begin
            s_d.min_v = vtrack_pkg::MIN_CLEARED;
            s_d.max_v = vtrack_pkg::MAX_CLEARED;
          end
        end else if (!(idx == {2'b00, vtrack_pkg::IDX_MIN_HI}
                       || idx == {2'b00, vtrack_pkg::IDX_MIN_LO}
                       || idx == {2'b00, vtrack_pkg::IDX_MAX_HI}
                       || idx == {2'b00, vtrack_pkg::IDX_MAX_LO})) begin
          s_d.pslverr = 1'b1;
        end
      end else begin
        // out-of-range index must not capture a shadow
        unique case ((idx[9:8] == 2'b00) ? idx[7:0] : 8'hFF)
          vtrack_pkg::IDX_MIN_HI: begin
            s_d.prdata        = {28'h0000000, s_q.min_v[11:8]};
            s_d.min_lo_shadow = s_q.min_v[7:0];
          end
          vtrack_pkg::IDX_MIN_LO: begin
            s_d.prdata = {24'h000000, s_q.min_lo_shadow};
          end
          vtrack_pkg::IDX_MAX_HI: begin
            s_d.prdata        = {28'h0000000, s_q.max_v[11:8]};
            s_d.max_lo_shadow = s_q.max_v[7:0];
          end
          vtrack_pkg::IDX_MAX_LO: begin
            s_d.prdata = {24'h000000, s_q.max_lo_shadow};
          end
          vtrack_pkg::IDX_CTRL: begin
            s_d.prdata = {31'h00000000, s_q.supply_config_select};
          end
          default: begin
            s_d.pslverr = 1'b1;
          end
        endcase
        if (idx[9:8] != 2'b00) begin
          s_d.prdata  = 32'h0000_0000;
          s_d.pslverr = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_q.min_v                <= vtrack_pkg::SAMPLE_RESET;
      s_q.max_v                <= vtrack_pkg::SAMPLE_RESET;
      s_q.min_lo_shadow        <= vtrack_pkg::RESET_BYTE;
      s_q.max_lo_shadow        <= vtrack_pkg::RESET_BYTE;
      s_q.supply_config_select <= 1'b0;
      s_q.pready               <= 1'b0;
      s_q.prdata               <= 32'h0000_0000;
      s_q.pslverr              <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pready               = s_q.pready;
  assign prdata               = s_q.prdata;
  assign pslverr              = s_q.pslverr;
  assign supply_config_select = s_q.supply_config_select;
endmodule
